// ==== rtl/ldp_defines.svh ====
// Register offsets, field positions, reset values and timing counts
// for the link diagnostics / phy access register block.
// Assumes inclusion by bare name from the design file and the testbench.
`ifndef LDP_DEFINES_SVH
`define LDP_DEFINES_SVH

`define LDP_OFS_DIAG 8'h20
`define LDP_OFS_PHY 8'h24

// Diagnostics fields (field bit 31 is the word's most significant bit)
`define LDP_D_SNOOP 31
`define LDP_D_BUSY_SEL 30
`define LDP_D_UNLOCK 27
`define LDP_D_ADR_CLR 26
`define LDP_D_CTRL_VAL 25
`define LDP_D_MISMATCH 24
`define LDP_D_RAM_TEST 23
`define LDP_D_SEL_A_HI 14
`define LDP_D_SEL_A_LO 12
`define LDP_D_SEL_B_HI 10
`define LDP_D_SEL_B_LO 8
`define LDP_D_ADDER_HI 7
`define LDP_D_ADDER_LO 3
`define LDP_D_MODE_LO 1
`define LDP_D_MODE_HI 0

// Phy access fields
`define LDP_P_RD 31
`define LDP_P_WR 30
`define LDP_P_ADDR_HI 27
`define LDP_P_ADDR_LO 24
`define LDP_P_WDATA_HI 23
`define LDP_P_WDATA_LO 16
`define LDP_P_RADDR_HI 11
`define LDP_P_RADDR_LO 8
`define LDP_P_RDATA_HI 7
`define LDP_P_RDATA_LO 0

`define LDP_ADDER_RST 5'h1f
`define LDP_ADDER_PLUS 6'h02
`define LDP_ADDER_ZERO_CYCLES 6'h22
`define LDP_PHY_RST 32'h00000000
`define LDP_RESP_OKAY 2'h0
`define LDP_RESP_DECERR 2'h3

`endif

// ==== rtl/ldp_pkg.sv ====
// Types shared by the register block.
// Assumes the defines header is on the include path.
package ldp_pkg;
  typedef enum logic [0:0] {ACK_IDLE, ACK_WAIT} ldp_ack_state_t;
endpackage

// ==== rtl/ldp_regs.sv ====
// Diagnostics and phy access registers behind an AXI4-Lite slave,
// with the fixed-timing select/acknowledge responder and phy request port.
// Assumes one 10 MHz clock; pins are asynchronous and are filtered here.
`include "ldp_defines.svh"

// Contract
// R1 - Snoop enable makes the receiver accept and deliver every packet in snoop form.
// R2 - Busy select chooses busy reply B when set, busy reply A when clear.
// R3 - Unlock bit lets software write normally protected bits.
// R4 - Address clear zeroes the RAM address counter and the mismatch flag.
// R5 - In RAM test, writes store the test control value; value resets clear.
// R6 - In RAM test, a stored control bit differing from value sets mismatch.
// R7 - RAM test is active only with test and unlock bits; test resets clear.
// R8 - Five-bit delay adder acts only in fixed pulse mode; resets to 1Fh.
// R9 - Fixed pulse mode answers each select pulse after adder plus two cycles.
// R10 - Adder of zero gives the maximum delay of 34 cycles.
// R11 - Host must not program the adder too low for its clock.
// R12 - Host should tune the adder once, using recommended values per clock.
// R13 - Two read-only diagnostics bits follow the two host mode pins.
// R14 - Upper phy access half carries requests, lower half carries replies.
// R15 - Read request bit sends a read to the phy, clears when sent.
// R16 - Write request bit sends address and data to the phy, clears when sent.
// R17 - Four-bit request address selects the target phy register.
// R18 - Eight-bit request data is the byte a write transfers.
// R19 - Reply fields capture the answering register address and data.
// R20 - Each phy reply raises the reply-received interrupt flag.
// R21 - Reply fields, busy select and mismatch are writable only when unlocked.
// R22 - Phy access sits at 24h, read/write, resets to zero.
// R23 - Reply fields update no later than the reply-received flag.
module ldp_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic host_mode_pin_lo,
  input wire logic host_mode_pin_hi,
  input wire logic fixed_pulse_mode_pin,
  input wire logic host_select_pulse,
  output logic host_ack_pulse,
  output logic snoop_enable,
  output logic busy_ack_select,
  output logic [2:0] status_out_select_a,
  output logic [2:0] status_out_select_b,
  input wire logic ram_access,
  input wire logic ram_write,
  input wire logic ram_ctrl_bit_rd,
  output logic ram_ctrl_bit_wr,
  output logic [7:0] ram_addr,
  output logic phy_req_valid,
  output logic phy_req_write,
  output logic [3:0] phy_req_addr,
  output logic [7:0] phy_req_wdata,
  input wire logic phy_req_ready,
  input wire logic phy_rsp_valid,
  input wire logic [3:0] phy_rsp_addr,
  input wire logic [7:0] phy_rsp_data,
  output logic phy_reply_received_irq
);

  function automatic logic [31:0] strb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old_v & ~m) | (new_v & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin filters: stage one feeds stage two only; a change counts once
  // stages two and three agree.
  logic [3:0] pin_s1, pin_s2, pin_s3, pin_f;
  logic fixed_mode;
  assign fixed_mode = pin_f[3];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_s3 <= 4'h0;
      pin_f <= 4'h0;
    end else begin
      pin_s1 <= {fixed_pulse_mode_pin, host_select_pulse, host_mode_pin_hi, host_mode_pin_lo};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int i = 0; i < 4; i++) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_f[i] <= pin_s3[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic aw_full, w_full, do_write;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  assign do_write = aw_full && w_full && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LDP_RESP_OKAY;
      wr_addr <= 8'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_addr == `LDP_OFS_DIAG || wr_addr == `LDP_OFS_PHY) ?
                       `LDP_RESP_OKAY : `LDP_RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  logic wr_diag, wr_phy, unlock;
  assign wr_diag = do_write && wr_addr == `LDP_OFS_DIAG;
  assign wr_phy = do_write && wr_addr == `LDP_OFS_PHY;

  ////////////////////////////////////////////////////////////////////////////
  // Diagnostics register
  logic [31:0] diag;
  logic [31:0] diag_mask;
  logic ram_test_active, mismatch_set, adr_clr;
  logic [4:0] adder;

  assign unlock = diag[`LDP_D_UNLOCK];
  assign adder = diag[`LDP_D_ADDER_HI:`LDP_D_ADDER_LO];
  // R7 test gate
  assign ram_test_active = diag[`LDP_D_RAM_TEST] && unlock;
  // R6 mismatch detect
  assign mismatch_set = ram_test_active && ram_access && !ram_write &&
                        (ram_ctrl_bit_rd != diag[`LDP_D_CTRL_VAL]);
  assign adr_clr = wr_diag && wr_strb[3] && wr_data[`LDP_D_ADR_CLR];

  // R3 unlock gating of protected bits
  always_comb begin
    diag_mask = 32'h00000000;
    diag_mask[`LDP_D_SNOOP] = 1'b1;
    diag_mask[`LDP_D_UNLOCK] = 1'b1;
    diag_mask[`LDP_D_CTRL_VAL] = 1'b1;
    diag_mask[`LDP_D_RAM_TEST] = 1'b1;
    diag_mask[`LDP_D_SEL_A_HI:`LDP_D_SEL_A_LO] = 3'h7;
    diag_mask[`LDP_D_SEL_B_HI:`LDP_D_SEL_B_LO] = 3'h7;
    diag_mask[`LDP_D_ADDER_HI:`LDP_D_ADDER_LO] = 5'h1f;
    // R21 busy select and mismatch
    diag_mask[`LDP_D_BUSY_SEL] = unlock;
    diag_mask[`LDP_D_MISMATCH] = unlock;
  end

  // Mode bits are not stored: reads take the filtered pins directly.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      diag <= 32'h00000000;
      // R8 adder reset value
      diag[`LDP_D_ADDER_HI:`LDP_D_ADDER_LO] <= `LDP_ADDER_RST;
    end else begin
      if (wr_diag) begin
        diag <= strb_merge(diag, wr_data, wr_strb, diag_mask);
      end
      // R4 clear of mismatch flag
      if (adr_clr) begin
        diag[`LDP_D_MISMATCH] <= 1'b0;
      end
      // Hardware set beats any clear in the same cycle
      if (mismatch_set) begin
        diag[`LDP_D_MISMATCH] <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      snoop_enable <= 1'b0;
      busy_ack_select <= 1'b0;
      status_out_select_a <= 3'h0;
      status_out_select_b <= 3'h0;
      ram_ctrl_bit_wr <= 1'b0;
    end else begin
      // R1 snoop control to receiver
      snoop_enable <= diag[`LDP_D_SNOOP];
      // R2 busy ack choice
      busy_ack_select <= diag[`LDP_D_BUSY_SEL];
      status_out_select_a <= diag[`LDP_D_SEL_A_HI:`LDP_D_SEL_A_LO];
      status_out_select_b <= diag[`LDP_D_SEL_B_HI:`LDP_D_SEL_B_LO];
      // R5 test value into control bit
      ram_ctrl_bit_wr <= ram_test_active && diag[`LDP_D_CTRL_VAL];
    end
  end

  // R4 address counter clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ram_addr <= 8'h00;
    end else if (adr_clr) begin
      ram_addr <= 8'h00;
    end else if (ram_access) begin
      ram_addr <= ram_addr + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fixed-timing select/acknowledge responder
  ldp_pkg::ldp_ack_state_t ack_state;
  logic sel_prev, sel_rise;
  logic [5:0] ack_cnt, delay_cycles;
  assign sel_rise = pin_f[2] && !sel_prev;
  // R10 zero means longest wait
  // R9 adder plus two
  assign delay_cycles = (adder == 5'h00) ? `LDP_ADDER_ZERO_CYCLES :
                        ({1'b0, adder} + `LDP_ADDER_PLUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_prev <= 1'b0;
      ack_state <= ldp_pkg::ACK_IDLE;
      ack_cnt <= 6'h00;
      host_ack_pulse <= 1'b0;
    end else begin
      sel_prev <= pin_f[2];
      host_ack_pulse <= 1'b0;
      case (ack_state)
        ldp_pkg::ACK_IDLE: begin
          // R8 only in fixed pulse mode
          if (sel_rise && fixed_mode) begin
            ack_cnt <= delay_cycles - 6'h01;
            ack_state <= ldp_pkg::ACK_WAIT;
          end
        end
        ldp_pkg::ACK_WAIT: begin
          if (ack_cnt == 6'h01) begin
            host_ack_pulse <= 1'b1;
            ack_state <= ldp_pkg::ACK_IDLE;
          end
          ack_cnt <= ack_cnt - 6'h01;
        end
        default: ack_state <= ldp_pkg::ACK_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phy access register
  logic [31:0] phy;
  logic [31:0] phy_mask;
  logic req_sent;
  assign req_sent = phy_req_valid && phy_req_ready;

  // R14 request half versus reply half
  always_comb begin
    phy_mask = 32'h00000000;
    phy_mask[`LDP_P_RD] = 1'b1;
    phy_mask[`LDP_P_WR] = 1'b1;
    phy_mask[`LDP_P_ADDR_HI:`LDP_P_ADDR_LO] = 4'hf;
    phy_mask[`LDP_P_WDATA_HI:`LDP_P_WDATA_LO] = 8'hff;
    // R21 reply fields only when unlocked
    phy_mask[`LDP_P_RADDR_HI:`LDP_P_RADDR_LO] = {4{unlock}};
    phy_mask[`LDP_P_RDATA_HI:`LDP_P_RDATA_LO] = {8{unlock}};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // R22 reset to zero
      phy <= `LDP_PHY_RST;
      phy_reply_received_irq <= 1'b0;
    end else begin
      phy_reply_received_irq <= 1'b0;
      if (wr_phy) begin
        phy <= strb_merge(phy, wr_data, wr_strb, phy_mask);
      end
      // R15 R16 self clear once sent
      if (req_sent && !(wr_phy && wr_strb[3])) begin
        if (phy_req_write) begin
          phy[`LDP_P_WR] <= 1'b0;
        end else begin
          phy[`LDP_P_RD] <= 1'b0;
        end
      end
      // R19 R23 capture together with the flag
      if (phy_rsp_valid) begin
        phy[`LDP_P_RADDR_HI:`LDP_P_RADDR_LO] <= phy_rsp_addr;
        phy[`LDP_P_RDATA_HI:`LDP_P_RDATA_LO] <= phy_rsp_data;
        // R20 reply flag
        phy_reply_received_irq <= 1'b1;
      end
    end
  end

  // Read is served before write when both are pending.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phy_req_valid <= 1'b0;
      phy_req_write <= 1'b0;
      phy_req_addr <= 4'h0;
      phy_req_wdata <= 8'h00;
    end else if (req_sent) begin
      phy_req_valid <= 1'b0;
    end else if (!phy_req_valid && (phy[`LDP_P_RD] || phy[`LDP_P_WR])) begin
      phy_req_valid <= 1'b1;
      phy_req_write <= !phy[`LDP_P_RD];
      // R17 target address
      phy_req_addr <= phy[`LDP_P_ADDR_HI:`LDP_P_ADDR_LO];
      // R18 write byte
      phy_req_wdata <= phy[`LDP_P_WDATA_HI:`LDP_P_WDATA_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h00000000;
    if (s_axi_araddr == `LDP_OFS_DIAG) begin
      rd_word = diag;
      // R13 mode pin levels
      rd_word[`LDP_D_MODE_LO] = pin_f[0];
      rd_word[`LDP_D_MODE_HI] = pin_f[1];
      rd_word[`LDP_D_ADR_CLR] = 1'b0;
    end else if (s_axi_araddr == `LDP_OFS_PHY) begin
      rd_word = phy;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `LDP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= (s_axi_araddr == `LDP_OFS_DIAG || s_axi_araddr == `LDP_OFS_PHY) ?
                     `LDP_RESP_OKAY : `LDP_RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [5:0] chk_wait, chk_exp;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chk_wait <= 6'h00;
      chk_exp <= 6'h00;
    end else if (ack_state == ldp_pkg::ACK_IDLE && sel_rise && fixed_mode) begin
      chk_wait <= 6'h01;
      chk_exp <= delay_cycles;
    end else if (chk_wait != 6'h00 && chk_wait != 6'h3f) begin
      chk_wait <= chk_wait + 6'h01;
    end
  end

  a_ack_delay_exact: assert property ( // R9
    host_ack_pulse |-> chk_wait == chk_exp) else $error("ack pulse at wrong delay");
  a_zero_adder_max: assert property ( // R10
    ack_state == ldp_pkg::ACK_IDLE && sel_rise && fixed_mode && adder == 5'h00
    |=> ack_cnt == 6'h21) else $error("zero adder not 34 cycles");
  a_no_ack_free_mode: assert property ( // R8
    ack_state == ldp_pkg::ACK_IDLE && sel_rise && !fixed_mode |=> !host_ack_pulse
    && ack_state == ldp_pkg::ACK_IDLE) else $error("ack outside fixed mode");
  a_mismatch_sets: assert property ( // R6
    mismatch_set |=> diag[`LDP_D_MISMATCH]) else $error("mismatch flag missed");
  a_adr_clear: assert property ( // R4
    adr_clr && !mismatch_set |=> ram_addr == 8'h00 && !diag[`LDP_D_MISMATCH])
    else $error("address clear failed");
  a_locked_reply: assert property ( // R21
    wr_phy && !unlock && !phy_rsp_valid |=> $stable(phy[15:0]))
    else $error("reply field written while locked");
  a_reply_capture: assert property ( // R19
    phy_rsp_valid |=> phy[`LDP_P_RDATA_HI:`LDP_P_RDATA_LO] == $past(phy_rsp_data)
    && phy_reply_received_irq) else $error("reply not captured");
  a_req_clears: assert property ( // R15
    req_sent && !phy_req_write && !(wr_phy && wr_strb[3]) |=> !phy[`LDP_P_RD])
    else $error("read request bit not cleared");
  a_req_fields: assert property ( // R17
    $rose(phy_req_valid) |-> phy_req_addr == phy[`LDP_P_ADDR_HI:`LDP_P_ADDR_LO])
    else $error("request address wrong");
  a_test_gate: assert property ( // R5
    ram_ctrl_bit_wr |-> $past(ram_test_active)) else $error("test bit outside test mode");

  c_ack_pulse: cover property (host_ack_pulse);
  c_phy_write: cover property (req_sent && phy_req_write);
  c_phy_reply: cover property (phy_rsp_valid ##1 s_axi_rvalid);
  c_mismatch: cover property (mismatch_set);

endmodule // ldp_regs

// ==== tb/ldp_phy_model.sv ====
// Behavioural phy chip facing the request and reply port of the block.
// Assumes the block's clock and reset; reads are answered two cycles after hand-over.
module ldp_phy_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [3:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [3:0] rsp_addr,
  output logic [7:0] rsp_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [16];
  logic [2:0] wait_cnt;
  logic [1:0] pend;
  logic [3:0] pend_addr;
  logic [3:0] last_addr;
  logic last_write;
  ////////////////////////////////////////
  // Slow mode holds ready off for four extra cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_ready <= 1'b0;
      wait_cnt <= 3'h0;
    end else if (req_valid && !req_ready) begin
      wait_cnt <= wait_cnt + 3'h1;
      req_ready <= !slow || wait_cnt == 3'h4;
    end else begin
      req_ready <= 1'b0;
      wait_cnt <= 3'h0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend <= 2'h0;
      rsp_valid <= 1'b0;
      rsp_addr <= 4'h0;
      rsp_data <= 8'h00;
      for (int i = 0; i < 16; i++) mem[i] <= 8'h30 + 8'(i);
    end else begin
      if (req_valid && req_ready) begin
        last_addr <= req_addr;
        last_write <= req_write;
        if (req_write) mem[req_addr] <= req_wdata;
        else pend <= 2'h2;
        pend_addr <= req_addr;
      end else if (pend != 2'h0) begin
        pend <= pend - 2'h1;
      end
      rsp_valid <= pend == 2'h1;
      // Idle reply lines toggle so stale values never look valid
      if (pend == 2'h1) begin
        rsp_addr <= pend_addr;
        rsp_data <= mem[pend_addr];
      end else begin
        rsp_addr <= ~rsp_addr;
        rsp_data <= ~rsp_data;
      end
    end
  end
endmodule // ldp_phy_model

// ==== tb/testbench.sv ====
// Self-checking bench for the diagnostics and phy access registers.
// Assumes the block's AXI4-Lite slave and the phy model on its request port.
`include "ldp_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pin_lo, pin_hi, fpm, sel, ack, snoop, busy;
  logic [7:0] awaddr, araddr, ram_addr, req_wdata, rsp_data;
  logic [2:0] awprot, arprot, sel_a, sel_b;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, req_addr, rsp_addr;
  logic [1:0] bresp, rresp;
  logic ram_access, ram_write, ctrl_rd, ctrl_wr, req_valid, req_write, req_ready;
  logic rsp_valid, irq, slow;
  int errors, n_compared;
  ldp_regs dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(arprot), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .host_mode_pin_lo(pin_lo),
    .host_mode_pin_hi(pin_hi), .fixed_pulse_mode_pin(fpm), .host_select_pulse(sel),
    .host_ack_pulse(ack), .snoop_enable(snoop), .busy_ack_select(busy),
    .status_out_select_a(sel_a), .status_out_select_b(sel_b), .ram_access(ram_access),
    .ram_write(ram_write), .ram_ctrl_bit_rd(ctrl_rd), .ram_ctrl_bit_wr(ctrl_wr),
    .ram_addr(ram_addr), .phy_req_valid(req_valid), .phy_req_write(req_write),
    .phy_req_addr(req_addr), .phy_req_wdata(req_wdata), .phy_req_ready(req_ready),
    .phy_rsp_valid(rsp_valid), .phy_rsp_addr(rsp_addr), .phy_rsp_data(rsp_data),
    .phy_reply_received_irq(irq)
  );
  ldp_phy_model phy_model (
    .aclk(aclk), .aresetn(aresetn), .slow(slow), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_addr(rsp_addr), .rsp_data(rsp_data)
  );
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic tmo;
    chk("wait bound", 32'h0, 32'h1);
    report_and_stop();
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 40) tmo();
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    d = rdata;
    if (n == 40) tmo();
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    axr(a, d, `LDP_RESP_OKAY);
    chk(nm, d, e);
  endtask
  task automatic wirq;
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (irq) break;
    end
    if (n == 40) tmo();
    @(posedge aclk);
    chk("irq pulse end", {31'h0, irq}, 32'h0);
  endtask
  task automatic ram_op(input logic w, input logic b);
    ram_write <= w;
    ctrl_rd <= b;
    ram_access <= 1'b1;
    @(posedge aclk);
    ram_access <= 1'b0;
    @(posedge aclk);
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    rd_chk("phy reset", `LDP_OFS_PHY, 32'h0);
    rd_chk("diag reset", `LDP_OFS_DIAG, 32'h0000_00fa);
    chk("outs reset", {29'h0, snoop, busy, ctrl_wr}, 32'h0);
  endtask
  task automatic t_unmapped;
    logic [31:0] d;
    axr(8'h28, d, `LDP_RESP_DECERR);
    chk("unmapped", d, 32'h0);
    axw(8'h2c, 32'hffff_ffff, `LDP_RESP_DECERR);
  endtask
  task automatic t_lock;
    axw(`LDP_OFS_DIAG, 32'h4000_00f8, `LDP_RESP_OKAY);
    rd_chk("busy locked", `LDP_OFS_DIAG, 32'h0000_00fa);
    chk("busy out locked", {31'h0, busy}, 32'h0);
    // Unlock must already stand before protected bits take a write
    axw(`LDP_OFS_DIAG, 32'h0800_00f8, `LDP_RESP_OKAY);
    axw(`LDP_OFS_DIAG, 32'hc800_77f8, `LDP_RESP_OKAY);
    rd_chk("diag unlocked", `LDP_OFS_DIAG, 32'hc800_77fa);
    chk("diag outs", {24'h0, snoop, busy, sel_a, sel_b}, 32'hff);
    axw(`LDP_OFS_PHY, 32'h0000_0c3c, `LDP_RESP_OKAY);
    rd_chk("reply unlocked", `LDP_OFS_PHY, 32'h0000_0c3c);
    axw(`LDP_OFS_DIAG, 32'h0800_00f8, `LDP_RESP_OKAY);
    axw(`LDP_OFS_DIAG, 32'h0000_00f8, `LDP_RESP_OKAY);
    axw(`LDP_OFS_PHY, 32'h0000_0a55, `LDP_RESP_OKAY);
    rd_chk("reply locked", `LDP_OFS_PHY, 32'h0000_0c3c);
  endtask
  task automatic t_phy;
    int n;
    logic [31:0] d;
    slow <= 1'b1;
    axw(`LDP_OFS_PHY, 32'h4ba5_0000, `LDP_RESP_OKAY);
    for (n = 0; n < 20; n++) begin
      axr(`LDP_OFS_PHY, d, `LDP_RESP_OKAY);
      if (!d[30]) break;
    end
    chk("write req clear", d, 32'h0ba5_0c3c);
    chk("phy byte", {24'h0, phy_model.mem[11]}, 32'ha5);
    chk("req kind", {27'h0, phy_model.last_write, phy_model.last_addr}, 32'h1b);
    axw(`LDP_OFS_PHY, 32'h8b00_0000, `LDP_RESP_OKAY);
    wirq();
    rd_chk("read reply", `LDP_OFS_PHY, 32'h0b00_0ba5);
    chk("req kind", {27'h0, phy_model.last_write, phy_model.last_addr}, 32'h0b);
    slow <= 1'b0;
    axw(`LDP_OFS_PHY, 32'h8300_0000, `LDP_RESP_OKAY);
    wirq();
    rd_chk("fast reply", `LDP_OFS_PHY, 32'h0300_0333);
  endtask
  task automatic t_ack(input logic [4:0] add, input int dly, input logic f);
    int k;
    fpm <= f;
    axw(`LDP_OFS_DIAG, {24'h0, add, 3'h0}, `LDP_RESP_OKAY);
    sel <= 1'b1;
    for (k = 1; k < 60; k++) begin
      @(posedge aclk);
      if (ack) break;
    end
    // Four filter edges, the delay, then one edge to see the pulse
    chk("ack timing", {31'h0, f ? k == dly + 5 : k == 60}, 32'h1);
    sel <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask
  task automatic t_ram;
    axw(`LDP_OFS_DIAG, 32'h0e80_0030, `LDP_RESP_OKAY);
    @(posedge aclk);
    chk("ram addr clr", {24'h0, ram_addr}, 32'h0);
    chk("test value out", {31'h0, ctrl_wr}, 32'h1);
    ram_op(1'b1, 1'b0);
    ram_op(1'b0, 1'b1);
    rd_chk("no mismatch", `LDP_OFS_DIAG, 32'h0a80_0032);
    ram_op(1'b0, 1'b0);
    chk("ram addr count", {24'h0, ram_addr}, 32'h3);
    rd_chk("mismatch set", `LDP_OFS_DIAG, 32'h0b80_0032);
    axw(`LDP_OFS_DIAG, 32'h0e80_0030, `LDP_RESP_OKAY);
    rd_chk("mismatch clr", `LDP_OFS_DIAG, 32'h0a80_0032);
    chk("ram addr clr2", {24'h0, ram_addr}, 32'h0);
    axw(`LDP_OFS_DIAG, 32'h0280_0030, `LDP_RESP_OKAY);
    @(posedge aclk);
    chk("test off out", {31'h0, ctrl_wr}, 32'h0);
    ram_op(1'b0, 1'b0);
    rd_chk("test off flag", `LDP_OFS_DIAG, 32'h0280_0032);
  endtask
  task automatic t_pins;
    pin_lo <= 1'b0;
    pin_hi <= 1'b1;
    repeat (5) @(posedge aclk);
    rd_chk("mode pins", `LDP_OFS_DIAG, 32'h0280_0031);
  endtask
  ////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    errors = 0;
    n_compared = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, sel, slow} = 8'h00;
    {ram_access, ram_write, ctrl_rd, pin_hi, awprot, arprot} = 10'h000;
    {awaddr, araddr, wdata} = 48'h0;
    {pin_lo, fpm, wstrb} = 6'h3f;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_unmapped();
    t_lock();
    t_phy();
    t_ack(5'h00, 34, 1'b1);
    t_ack(5'h01, 3, 1'b1);
    t_ack(5'h1f, 33, 1'b1);
    // a safe value for this clock, tuned once and then left alone
    t_ack(5'h06, 8, 1'b1);
    t_ack(5'h06, 8, 1'b0);
    t_ram();
    t_pins();
    report_and_stop();
  end
endmodule // testbench
